// File: include/tgc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TGC_DEFS_SVH
`define TGC_DEFS_SVH
`define TGC_ADDR_W        8
`define TGC_RUN_OFS       8'h00
`define TGC_MODE_OFS      8'h04
`define TGC_PSC_OFS       8'h08
`define TGC_RUN_W         10
`define TGC_RUN_RST       10'h000
`define TGC_MODE_W        3
`define TGC_MODE_RST      3'h0
`define TGC_MODE_CH5_BIT  2
`define TGC_MODE_CH4_BIT  1
`define TGC_MODE_CH3_BIT  0
`define TGC_PSC_W         5
`define TGC_PSC_RST       5'h00
`define TGC_NUM_CH        10
`define TGC_CNT_W         16
`define TGC_DIV_STEPS     6
`define TGC_DIV_W         5
`define TGC_RESP_OKAY     2'h0
`define TGC_RESP_SLVERR   2'h2
`endif

// File: include/tgc_pkg.sv
// Types shared by the timer global control block
package tgc_pkg;
  typedef enum logic [1:0] {
    TGC_REG_RUN,
    TGC_REG_MODE,
    TGC_REG_PSC,
    TGC_REG_NONE
  } tgc_reg_e;

  typedef struct packed {
    logic       pwm_enable_ch5;
    logic       pwm_enable_ch4;
    logic       pwm_enable_ch3;
  } tgc_mode_s;

  typedef struct packed {
    logic       timer_io_a_ch5;
    logic [2:0] timer_io_ch4;
    logic [2:0] timer_io_ch3;
    logic       period_b_ch5;
    logic       period_d_ch4;
    logic       period_d_ch3;
  } tgc_pwm_route_s;

  typedef logic [9:0][15:0] tgc_cnt_t;
  typedef logic [9:1][2:0]  tgc_sel_t;
endpackage

// File: hdl/tgc_top.sv
// Timer unit global control: run bits, PWM mode select, prescaler, counters
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "tgc_defs.svh"

module tgc_top
  import tgc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   standby,
  input  wire tgc_sel_t               chan_clk_sel,
  input  wire logic [`TGC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TGC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [`TGC_RUN_W-1:0]       run_ch,
  output tgc_mode_s                   mode,
  output tgc_pwm_route_s              pwm_route,
  output logic                        first_stage_tick,
  output logic [`TGC_DIV_STEPS-1:0]   stage2_tick,
  output tgc_cnt_t                    free_running_counter
);

  logic [`TGC_RUN_W-1:0]     run_r;
  tgc_mode_s                 mode_r;
  logic [`TGC_PSC_W-1:0]     psc_r;
  logic [`TGC_PSC_W-1:0]     psc_cnt_r;
  logic                      psc_tick_r;
  logic [`TGC_DIV_W-1:0]     div_r;
  logic [`TGC_DIV_STEPS-1:0] tick_r;
  logic [`TGC_DIV_STEPS-1:0] tick_nxt;
  tgc_cnt_t                  cnt_r;
  tgc_pwm_route_s            route_r;
  logic                      awready_r;
  logic                      wready_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      arready_r;
  logic                      rvalid_r;
  logic [1:0]                rresp_r;
  logic [31:0]               rdata_r;
  logic [`TGC_ADDR_W-1:0]    waddr_r;
  logic                      wr_en;
  logic                      rd_en;
  tgc_reg_e                  wr_idx;
  tgc_reg_e                  rd_idx;

  // Address decode shared by read and write paths
  function automatic tgc_reg_e dec(input logic [`TGC_ADDR_W-1:0] a);
    unique case (a)
      `TGC_RUN_OFS:  dec = TGC_REG_RUN;
      `TGC_MODE_OFS: dec = TGC_REG_MODE;
      `TGC_PSC_OFS:  dec = TGC_REG_PSC;
      default:       dec = TGC_REG_NONE;
    endcase
  endfunction

  // Tick picked by a channel clock select; codes 6 and 7 give none
  function automatic logic sel_tick(input logic [2:0] sel,
                                    input logic [`TGC_DIV_STEPS-1:0] t);
    sel_tick = (sel < 3'h6) ? t[sel] : 1'b0;
  endfunction

  // Write address and data taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      waddr_r   <= '0;
    end else if (awready_r) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_wvalid && !bvalid_r) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      waddr_r   <= s_axi_awaddr;
    end
  end

  assign wr_en  = awready_r && s_axi_awvalid && s_axi_wvalid;
  assign wr_idx = dec(waddr_r);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `TGC_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_idx == TGC_REG_NONE) ? `TGC_RESP_SLVERR : `TGC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read address accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
    end
  end

  assign rd_en  = arready_r && s_axi_arvalid;
  assign rd_idx = dec(s_axi_araddr);

  // Read data; unused upper bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `TGC_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_en) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `TGC_RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      unique case (rd_idx)
        TGC_REG_RUN:  rdata_r[`TGC_RUN_W-1:0]  <= run_r;
        TGC_REG_MODE: rdata_r[`TGC_MODE_W-1:0] <= mode_r;
        TGC_REG_PSC:  rdata_r[`TGC_PSC_W-1:0]  <= psc_r;
        TGC_REG_NONE: rresp_r <= `TGC_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Run register; standby clears it like reset
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      run_r <= `TGC_RUN_RST;
    end else if (wr_en && wr_idx == TGC_REG_RUN) begin
      if (s_axi_wstrb[0]) begin
        run_r[7:0] <= s_axi_wdata[7:0];
      end
      if (s_axi_wstrb[1]) begin
        run_r[9:8] <= s_axi_wdata[9:8];
      end
    end
  end

  // Mode register; upper bits not stored
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      mode_r <= `TGC_MODE_RST;
    end else if (wr_en && wr_idx == TGC_REG_MODE && s_axi_wstrb[0]) begin
      mode_r <= s_axi_wdata[`TGC_MODE_W-1:0];
    end
  end

  // Prescaler register; bits 7..5 dropped
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      psc_r <= `TGC_PSC_RST;
    end else if (wr_en && wr_idx == TGC_REG_PSC && s_axi_wstrb[0]) begin
      psc_r <= s_axi_wdata[`TGC_PSC_W-1:0];
    end
  end

  // First stage divider, one tick every psc_r plus one cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_cnt_r  <= '0;
      psc_tick_r <= 1'b0;
    end else if (psc_cnt_r >= psc_r) begin
      psc_cnt_r  <= '0;
      psc_tick_r <= 1'b1;
    end else begin
      psc_cnt_r  <= psc_cnt_r + 5'h01;
      psc_tick_r <= 1'b0;
    end
  end

  // Second stage divider over first stage ticks
  always_comb begin
    tick_nxt[0] = psc_tick_r;
    for (int k = 1; k < `TGC_DIV_STEPS; k++) begin
      tick_nxt[k] = psc_tick_r && ((div_r | ~(5'h1f >> (`TGC_DIV_W - k))) == 5'h1f);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= '0;
      tick_r <= '0;
    end else begin
      tick_r <= tick_nxt;
      if (psc_tick_r) begin
        div_r <= div_r + 5'h01;
      end
    end
  end

  // Free-running counters; channel 0 on the first stage tick, channels 1 to 9 on the tick chan_clk_sel picks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      if (run_r[0] && tick_r[0]) begin
        cnt_r[0] <= cnt_r[0] + 16'h0001;
      end
      for (int c = 1; c < `TGC_NUM_CH; c++) begin
        if (run_r[c] && sel_tick(chan_clk_sel[c], tick_r)) begin
          cnt_r[c] <= cnt_r[c] + 16'h0001;
        end
      end
    end
  end

  // PWM pin and register roles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r <= '0;
    end else begin
      route_r.timer_io_a_ch5 <= mode_r.pwm_enable_ch5;
      route_r.period_b_ch5   <= mode_r.pwm_enable_ch5;
      route_r.timer_io_ch4   <= {3{mode_r.pwm_enable_ch4}};
      route_r.period_d_ch4   <= mode_r.pwm_enable_ch4;
      route_r.timer_io_ch3   <= {3{mode_r.pwm_enable_ch3}};
      route_r.period_d_ch3   <= mode_r.pwm_enable_ch3;
    end
  end

  assign s_axi_awready        = awready_r;
  assign s_axi_wready         = wready_r;
  assign s_axi_bvalid         = bvalid_r;
  assign s_axi_bresp          = bresp_r;
  assign s_axi_arready        = arready_r;
  assign s_axi_rvalid         = rvalid_r;
  assign s_axi_rresp          = rresp_r;
  assign s_axi_rdata          = rdata_r;
  assign run_ch               = run_r;
  assign mode                 = mode_r;
  assign pwm_route            = route_r;
  assign first_stage_tick     = psc_tick_r;
  assign stage2_tick          = tick_r;
  assign free_running_counter = cnt_r;

  // Checks
  logic [5:0] gap_r;
  logic       gap_ok_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r    <= 6'h01;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= psc_tick_r ? 6'h01 : gap_r + 6'h01;
      if (standby || (wr_en && wr_idx == TGC_REG_PSC)) begin
        gap_ok_r <= 1'b0;
      end else if (psc_tick_r) begin
        gap_ok_r <= 1'b1;
      end
    end
  end

  sequence s_wr_take;
    wr_en && wr_idx != TGC_REG_NONE;
  endsequence
  sequence s_rd_take(tgc_reg_e r);
    rd_en && rd_idx == r;
  endsequence
  property p_halt_keeps;
    @(posedge aclk) disable iff (!aresetn)
    !run_r[0] |=> cnt_r[0] == $past(cnt_r[0]);
  endproperty
  a_halt_keeps: assert property (p_halt_keeps)
    else $error("halted counter 0 moved");
  property p_run_ch8;
    @(posedge aclk) disable iff (!aresetn)
    run_r[8] && sel_tick(chan_clk_sel[8], tick_r) |=>
      cnt_r[8] == $past(cnt_r[8]) + 16'h0001;
  endproperty
  a_run_ch8: assert property (p_run_ch8)
    else $error("counter 8 did not advance");
  property p_run_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(TGC_REG_RUN) |=> rvalid_r && rdata_r[31:10] == 22'h0;
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("run read upper bits not zero");
  property p_mode_write;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_take ##0 (wr_idx == TGC_REG_MODE && s_axi_wstrb[0] && !standby) |=>
      mode_r == $past(s_axi_wdata[2:0]) && bvalid_r;
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write not stored");
  property p_mode_standby;
    @(posedge aclk) disable iff (!aresetn)
    standby |=> mode_r == 3'h0 && run_r == 10'h000;
  endproperty
  a_mode_standby: assert property (p_mode_standby)
    else $error("standby did not clear");
  property p_mode_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(TGC_REG_MODE) |=> rdata_r[31:3] == 29'h0;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode reserved bits not zero");
  property p_route;
    @(posedge aclk) disable iff (!aresetn)
    $rose(mode_r.pwm_enable_ch4) |=>
      route_r.timer_io_ch4 == 3'h7 && route_r.period_d_ch4;
  endproperty
  a_route: assert property (p_route)
    else $error("channel 4 pwm route missing");
  property p_psc_gap;
    @(posedge aclk) disable iff (!aresetn)
    psc_tick_r && gap_ok_r && $stable(psc_r) |->
      gap_r == {1'b0, psc_r} + 6'h01;
  endproperty
  a_psc_gap: assert property (p_psc_gap)
    else $error("prescaler period wrong");
  property p_stage2;
    @(posedge aclk) disable iff (!aresetn)
    tick_r[1] |-> tick_r[0] ##1 !tick_r[1] ##1 !tick_r[1] || tick_r[0];
  endproperty
  a_stage2: assert property (p_stage2)
    else $error("stage two tick off first stage");
  property p_psc_standby;
    @(posedge aclk) disable iff (!aresetn)
    standby ##1 standby |=> psc_r == 5'h00 && psc_tick_r ##1 psc_tick_r;
  endproperty
  a_psc_standby: assert property (p_psc_standby)
    else $error("prescaler not cleared by standby");
  property p_psc_read;
    @(posedge aclk) disable iff (!aresetn)
    s_rd_take(TGC_REG_PSC) |=> rdata_r[31:5] == 27'h0 && rdata_r[4:0] == $past(psc_r);
  endproperty
  a_psc_read: assert property (p_psc_read)
    else $error("prescaler read wrong");

endmodule

// File: dv/tgc_tb.sv
// Self-checking testbench for the timer global control block
`timescale 1ns/10ps
`include "tgc_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end

module testbench
  import tgc_pkg::*;
;
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic                   standby = 1'b0;
  tgc_sel_t               chan_clk_sel = '0;
  logic [`TGC_ADDR_W-1:0] awaddr = '0;
  logic                   awvalid = 1'b0;
  logic                   awready;
  logic [31:0]            wdata = '0;
  logic                   wvalid = 1'b0;
  logic [3:0]             wstrb = 4'hf;
  logic                   wready;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   bready = 1'b0;
  logic [`TGC_ADDR_W-1:0] araddr = '0;
  logic                   arvalid = 1'b0;
  logic                   arready;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  logic                   rready = 1'b0;
  logic [`TGC_RUN_W-1:0]  run_ch;
  tgc_mode_s              mode;
  tgc_pwm_route_s         pwm_route;
  logic                   first_stage_tick;
  logic [5:0]             stage2_tick;
  tgc_cnt_t               cnt;
  int                     n_fail = 0;
  int                     checks = 0;
  int                     cyc = 0;
  logic [7:0]             ofs [3] = '{`TGC_RUN_OFS, `TGC_MODE_OFS, `TGC_PSC_OFS};
  logic [31:0]            msk [3] = '{32'h3ff, 32'h7, 32'h1f};
  logic [31:0]            rd;
  logic [1:0]             rsp;
  logic [31:0]            d;
  logic [4:0]             p;
  logic [9:0]             rm;
  tgc_sel_t               sel;
  tgc_cnt_t               c0;
  tgc_cnt_t               c1;
  int                     nt;
  int                     nt5;

  always #5 aclk = ~aclk;

  tgc_top dut_u (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .standby              (standby),
    .chan_clk_sel         (chan_clk_sel),
    .s_axi_awaddr         (awaddr),
    .s_axi_awvalid        (awvalid),
    .s_axi_awready        (awready),
    .s_axi_wdata          (wdata),
    .s_axi_wstrb          (wstrb),
    .s_axi_wvalid         (wvalid),
    .s_axi_wready         (wready),
    .s_axi_bresp          (bresp),
    .s_axi_bvalid         (bvalid),
    .s_axi_bready         (bready),
    .s_axi_araddr         (araddr),
    .s_axi_arvalid        (arvalid),
    .s_axi_arready        (arready),
    .s_axi_rdata          (rdata),
    .s_axi_rresp          (rresp),
    .s_axi_rvalid         (rvalid),
    .s_axi_rready         (rready),
    .run_ch               (run_ch),
    .mode                 (mode),
    .pwm_route            (pwm_route),
    .first_stage_tick     (first_stage_tick),
    .stage2_tick          (stage2_tick),
    .free_running_counter (cnt)
  );

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic check_regs(input logic [31:0] e0, input logic [31:0] e1,
                            input logic [31:0] e2);
    logic [31:0] ex [3];
    ex = '{e0, e1, e2};
    for (int i = 0; i < 3; i++) begin
      rdr(ofs[i], rd, rsp);
      `CHK("reg read", ex[i] & msk[i], rd)
      `CHK("read resp", `TGC_RESP_OKAY, rsp)
    end
  endtask

  function automatic tgc_pwm_route_s exp_route(input logic [2:0] m);
    tgc_pwm_route_s r;
    r.timer_io_a_ch5 = m[2];
    r.timer_io_ch4 = {3{m[1]}};
    r.timer_io_ch3 = {3{m[0]}};
    r.period_b_ch5 = m[2];
    r.period_d_ch4 = m[1];
    r.period_d_ch3 = m[0];
    return r;
  endfunction

  function automatic logic [15:0] exp_delta(input logic run, input logic [2:0] s);
    if (!run || s > 3'd5) return 16'h0000;
    return 16'(64 >> s);
  endfunction

  initial begin
    void'($urandom(32'ha66737a9));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check_regs(0, 0, 0);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom & 32'h3ff;
      wr(`TGC_RUN_OFS, d, rsp);
      wr(`TGC_MODE_OFS, 32'(i), rsp);
      wr(`TGC_PSC_OFS, $urandom & 32'hff, rsp);
      @(posedge aclk);
      `CHK("run out", d[9:0], run_ch)
      `CHK("mode out", 3'(i), mode)
      `CHK("route", exp_route(3'(i)), pwm_route)
      rdr(`TGC_RUN_OFS, rd, rsp);
      `CHK("run rd", d, rd)
    end
    wr(8'h0c, 32'h3ff, rsp);
    `CHK("bad wr resp", `TGC_RESP_SLVERR, rsp)
    rdr(8'h10, rd, rsp);
    `CHK("bad rd resp", `TGC_RESP_SLVERR, rsp)
    `CHK("run kept", d[9:0], run_ch)
    wstrb <= 4'h1;
    wr(`TGC_RUN_OFS, ~d, rsp);
    wstrb <= 4'hf;
    `CHK("wr resp", `TGC_RESP_OKAY, rsp)
    `CHK("run strobe", {d[9:8], ~d[7:0]}, run_ch)
    $display("test register_access done");
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom_range(30, 1));
      rm = (i == 0) ? 10'h3ff : 10'($urandom);
      for (int c = 1; c < 10; c++) sel[c] = 3'($urandom_range(7, 0));
      chan_clk_sel <= sel;
      wr(`TGC_PSC_OFS, 32'(p), rsp);
      wr(`TGC_RUN_OFS, 32'(rm), rsp);
      @(posedge aclk);
      c0 = cnt;
      nt = 0;
      nt5 = 0;
      repeat ((int'(p) + 1) * 64) begin
        @(posedge aclk);
        if (first_stage_tick === 1'b1) nt++;
        if (stage2_tick[5] === 1'b1) nt5++;
      end
      c1 = cnt;
      `CHK("tick count", 64, nt)
      `CHK("stage2 count", 2, nt5)
      `CHK("ch0 delta", exp_delta(rm[0], 3'd0), 16'(c1[0] - c0[0]))
      for (int c = 1; c < 10; c++) begin
        `CHK("ch delta", exp_delta(rm[c], sel[c]), 16'(c1[c] - c0[c]))
      end
    end
    $display("test counting done");
    wr(`TGC_MODE_OFS, 32'h7, rsp);
    @(posedge aclk);
    standby <= 1'b1;
    repeat (3) @(posedge aclk);
    standby <= 1'b0;
    repeat (2) @(posedge aclk);
    c0 = cnt;
    check_regs(0, 0, 0);
    `CHK("run standby", 10'h000, run_ch)
    `CHK("mode standby", 3'h0, mode)
    `CHK("route standby", exp_route(3'h0), pwm_route)
    `CHK("cnt held", c0, cnt)
    $display("test standby done");
    wr(`TGC_RUN_OFS, 32'h3ff, rsp);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    `CHK("cnt reset", tgc_cnt_t'('0), cnt)
    `CHK("run reset", 10'h000, run_ch)
    aresetn <= 1'b1;
    check_regs(0, 0, 0);
    $display("test second_reset done");
    stop_test();
  end
endmodule
